// file: dv/ctrl_pin_source.sv
// Purpose: far-side controller driving the sweep control pin
// Assumes: go is a one-cycle request, hold is the high time in clocks
// Notes: also makes a waveform-cycle pulse every third clock
module ctrl_pin_source (
    input wire logic clk,
    input wire logic nrst,
    input wire logic go,
    input wire logic [7:0] hold,
    output logic ctrl_pin,
    output logic wave_cycle
);
    logic [7:0] cnt_r;
    logic [1:0] div_r;

    // ========================================================
    // pin pulse, high for hold clocks then low
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_r <= 8'h00;
            ctrl_pin <= 1'b0;
        end else if (go && cnt_r == 8'h00) begin
            cnt_r <= hold;
            ctrl_pin <= 1'b1;
        end else if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
        end else begin
            cnt_r <= 8'h00;
            ctrl_pin <= 1'b0;
        end
    end

    // ========================================================
    // waveform cycle pulse from a divide-by-three
    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_r <= 2'h0;
        end else begin
            div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
        end
    end
    assign wave_cycle = (div_r == 2'h2);
endmodule

// file: dv/sweep_timing_chk.sv
// Purpose: port-level checks of the sweep interval and burst timing block
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every instance of the top module
module sweep_timing_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [15:0] rdata,
    input wire logic ctrl_pin,
    input wire logic wave_cycle,
    input wire logic [23:0] freq_word,
    input wire logic midscale,
    input wire logic sweep_active,
    input wire logic step_pulse,
    input wire logic sweep_done
);
    // ========================================================
    // sweep sequencing and read port
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    done_ends_sweep_a: assert property (
        sweep_done |-> !sweep_active && midscale && $past(sweep_active))
        else $error("sweep end not clean");
    step_in_burst_a: assert property (
        step_pulse |-> sweep_active && !midscale)
        else $error("step outside output phase");
    step_single_a: assert property (
        step_pulse |=> !step_pulse)
        else $error("step pulse too long");
    freq_on_step_a: assert property (
        sweep_active && $past(sweep_active) && $changed(freq_word)
        |-> step_pulse)
        else $error("frequency moved without a step");
    start_outputs_a: assert property (
        $rose(sweep_active) |-> !midscale && !step_pulse)
        else $error("sweep start not outputting");
    start_needs_pin_a: assert property (
        $rose(sweep_active) |-> $past(ctrl_pin, 3))
        else $error("sweep started without pin rise");
    idle_midscale_a: assert property (
        !sweep_active |-> midscale)
        else $error("idle output not midscale");
    rdata_quiet_a: assert property (
        !$past(rd_en) |-> rdata == 16'h0000)
        else $error("read data outside read slot");
    unmapped_zero_a: assert property (
        $past(rd_en) && $past(addr) > 4'h6 |-> rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule

bind sweep_interval_burst_timing sweep_timing_chk chk_i (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .ctrl_pin(ctrl_pin),
    .wave_cycle(wave_cycle), .freq_word(freq_word), .midscale(midscale),
    .sweep_active(sweep_active), .step_pulse(step_pulse),
    .sweep_done(sweep_done)
);

// file: dv/tb_sweep_interval_burst_timing.sv
// Purpose: self-checking bench of the sweep interval and burst timing
// Assumes: config words written at address 0, pin from ctrl_pin_source
// Notes: sweep lengths measured from the start cycle to the done pulse
module tb_sweep_interval_burst_timing;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [23:0] START = 24'h45_6123;
    logic clk, nrst, wr_en, rd_en, go, ctrl_pin, wave_cycle;
    logic [3:0] addr;
    logic [15:0] wdata, rdata;
    logic [7:0] hold;
    logic [23:0] freq_word;
    logic midscale, sweep_active, step_pulse, sweep_done;
    int err_total = 0;
    int check_count = 0;
    int mul[4] = '{1, 5, 100, 500};

    sweep_interval_burst_timing uut (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .ctrl_pin(ctrl_pin), .wave_cycle(wave_cycle),
        .freq_word(freq_word), .midscale(midscale),
        .sweep_active(sweep_active), .step_pulse(step_pulse),
        .sweep_done(sweep_done));
    ctrl_pin_source far_i (.clk(clk), .nrst(nrst), .go(go), .hold(hold),
        .ctrl_pin(ctrl_pin), .wave_cycle(wave_cycle));

    // ========================================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #(20000 * 5);
        err_total++;
        summarize();
    end

    // ========================================================
    // access tasks
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e,
                      input string name);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk(name, {16'h0000, rdata}, {16'h0000, e});
    endtask
    task automatic pulse(input logic [7:0] h);
        @(posedge clk);
        go <= 1'b1;
        hold <= h;
        @(posedge clk);
        go <= 1'b0;
    endtask

    // ========================================================
    // automatic sweep: total, first listen cycle, steps and values
    task automatic auto_run(input int tot, input int bur,
                            input logic [23:0] d);
        int n, fm, ns;
        n = 0;
        fm = -1;
        ns = 0;
        pulse(8'h04);
        while (sweep_active !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk("start_freq", freq_word, START);
        n = 0;
        while (sweep_done !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
            if (midscale === 1'b1 && fm < 0) fm = n;
            if (step_pulse === 1'b1) begin
                ns++;
                chk("step_freq", freq_word, 24'(START + ns * d));
            end
        end
        chk("sweep_len", n, tot);
        chk("burst_len", fm, bur);
        chk("step_count", ns, 2);
    endtask

    // ========================================================
    // external sweep: start, two steps, end, burst after each pulse but the end
    task automatic ext_run(input logic [7:0] h, input int bur,
                           input int tol, input logic [23:0] d);
        int n, k;
        logic ev;
        for (k = 0; k < 4; k++) begin
            pulse(h);
            n = 0;
            ev = 1'b0;
            while (ev !== 1'b1 && n < 20) begin
                @(negedge clk);
                n++;
                ev = (k == 0) ? sweep_active :
                     (k == 3) ? sweep_done : step_pulse;
            end
            chk("ext_event", ev, 1'b1);
            if (k < 3) begin
                chk("ext_freq", freq_word, 24'(START + k * d));
                n = 0;
                while (midscale !== 1'b1 && n < 40) begin
                    @(negedge clk);
                    n++;
                end
                chk("ext_burst", n >= bur - tol && n <= bur + tol, 1);
            end
            repeat (4) @(posedge clk);
        end
    endtask

    task automatic summarize;
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ========================================================
    // main sequence
    initial begin
        nrst = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        go = 1'b0;
        hold = 8'h00;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(4'h5, 16'h2002, "interval_rst");
        rd(4'h6, 16'h2001, "burst_rst");
        wr(4'h0, 16'h6005);
        wr(4'h5, 16'h6007);
        rd(4'h5, 16'h2005, "interval_rd");
        wr(4'h0, 16'h9803);
        rd(4'h6, 16'h1803, "burst_rd");
        rd(4'h9, 16'h0000, "unmapped");
        wr(4'h0, 16'hC123);
        wr(4'h0, 16'hD456);
        wr(4'h0, 16'h2010);
        wr(4'h0, 16'h3000);
        wr(4'h0, 16'h1002);
        // burst word asks cycles and x500: interval word must win
        wr(4'h0, 16'h9801);
        for (int m = 0; m < 4; m++) begin
            wr(4'h0, {3'b011, 2'(m), 11'h002});
            auto_run(6 * mul[m], mul[m], 24'h00_0010);
        end
        // idle status and the last frequency of the finished sweep
        rd(4'h1, 16'h0009, "status_idle");
        rd(4'h2, 16'h0143, "freq_lo");
        rd(4'h3, 16'h0456, "freq_hi");
        rd(4'h4, 16'h0002, "steps_taken");
        // continuous output, falling sweep; lone wide low half stays held
        wr(4'h0, 16'h3800);
        wr(4'h0, 16'h0880);
        wr(4'h0, 16'hC777);
        wr(4'h0, 16'h6004);
        auto_run(12, 12, 24'hFF_FFF0);
        // external increment, burst word timing
        wr(4'h0, 16'h3000);
        wr(4'h0, 16'h0020);
        wr(4'h0, 16'h7802);
        wr(4'h0, 16'hA003);
        ext_run(8'h02, 3, 0, 24'h00_0010);
        // fully external, pin high time is the burst
        wr(4'h0, 16'h0040);
        ext_run(8'h06, 6, 1, 24'h00_0010);
        summarize();
    end
endmodule

// file: logic/pin_edge_sync.sv
// Purpose: bring the control pin into the clock domain
// Assumes: one clock, synchronous active-low reset
// Notes: level and rise are valid two edges after the pin moves
module pin_edge_sync (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pin,
    output logic level,
    output logic rise
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    // ========================================================
    // two-stage synchroniser, then edge history
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // level and rising edge seen only after the second stage
    assign level = sync_r;
    assign rise = sync_r & ~prev_r;

endmodule

// file: logic/sweep_interval_burst_timing.sv
// Purpose: interval, burst and stepping control of a frequency sweep
// Assumes: wave_cycle pulses once per output waveform cycle
// Notes: config words are written whole at the command address
`include "sweep_timing_regs.svh"

module sweep_interval_burst_timing (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rdata,
    input wire logic ctrl_pin,
    input wire logic wave_cycle,
    output logic [23:0] freq_word,
    output logic midscale,
    output logic sweep_active,
    output logic step_pulse,
    output logic sweep_done
);

    // ========================================================
    // decoders

    // stepping mode from the two mode bits; unused code runs auto
    function automatic sweep_timing_pkg::mode_type step_mode(
        input logic [1:0] code
    );
        sweep_timing_pkg::mode_type m;
        m = sweep_timing_pkg::MODE_AUTO;
        if (code == `MODE_CODE_EXT_INC) begin
            m = sweep_timing_pkg::MODE_EXT_INC;
        end else if (code == `MODE_CODE_EXT_BOTH) begin
            m = sweep_timing_pkg::MODE_EXT_BOTH;
        end
        return m;
    endfunction

    // prescale limit of the time-base multiplier
    function automatic logic [8:0] mult_limit(input logic [1:0] code);
        logic [8:0] lim;
        lim = `MULT_LIMIT_1;
        unique case (code)
            2'b00: lim = `MULT_LIMIT_1;
            2'b01: lim = `MULT_LIMIT_5;
            2'b10: lim = `MULT_LIMIT_100;
            2'b11: lim = `MULT_LIMIT_500;
        endcase
        return lim;
    endfunction

    // ========================================================
    // configuration storage
    logic [11:0] control_r;
    logic [11:0] incr_count_r;
    logic [11:0] step_lo_r;
    logic [10:0] step_hi_r;
    logic step_neg_r;
    logic [11:0] start_lo_r;
    logic [11:0] start_hi_r;
    logic [11:0] start_lo_hold_r;
    logic interval_sel_r;
    logic [1:0] interval_mult_r;
    logic [10:0] interval_count_r;
    logic burst_sel_r;
    logic [1:0] burst_mult_r;
    logic [10:0] burst_count_r;

    // sequencer state
    sweep_timing_pkg::state_type state_r;
    sweep_timing_pkg::state_type state_nxt;
    logic [8:0] prescale_r;
    logic [10:0] unit_cnt_r;
    logic [11:0] step_cnt_r;
    logic [23:0] freq_r;
    logic midscale_r;
    logic sweep_active_r;
    logic step_pulse_r;
    logic sweep_done_r;
    logic [15:0] rdata_r;

    // control pin view
    logic ctrl_level;
    logic ctrl_rise;

    // derived timing terms
    sweep_timing_pkg::mode_type mode;
    logic cw;
    logic time_sel;
    logic [1:0] time_mult;
    logic [8:0] prescale_lim;
    logic tick;
    logic running;
    logic start_ev;
    logic ext_step_ev;
    logic auto_int_end;
    logic int_end;
    logic step_ev;
    logic end_ev;
    logic restart;
    logic burst_end;
    logic [23:0] step_mag;
    logic [23:0] step_add;

    // ========================================================
    // control pin synchroniser and edge detector
    pin_edge_sync u_ctrl_sync (
        .clk(clk),
        .nrst(nrst),
        .pin(ctrl_pin),
        .level(ctrl_level),
        .rise(ctrl_rise)
    );

    // ========================================================
    // configuration word writes, decoded by top bits
    always_ff @(posedge clk) begin
        if (!nrst) begin
            control_r <= `RST_CONTROL;
            incr_count_r <= `RST_INCR_COUNT;
            step_lo_r <= 12'h000;
            step_hi_r <= 11'h000;
            step_neg_r <= 1'b0;
            start_lo_r <= 12'h000;
            start_hi_r <= 12'h000;
            start_lo_hold_r <= 12'h000;
        end else if (wr_en && addr == `ADDR_CMD) begin
            casez (wdata[15:12])
                `CMD_CONTROL: begin
                    control_r <= wdata[11:0];
                end
                `CMD_INCR_COUNT: begin
                    incr_count_r <= wdata[11:0];
                end
                `CMD_STEP_LO: begin
                    step_lo_r <= wdata[11:0];
                end
                `CMD_STEP_HI: begin
                    step_neg_r <= wdata[`FLD_STEP_NEG_BIT];
                    step_hi_r <= wdata[`FLD_CNT_HI:0];
                end
                `CMD_START_LO: begin
                    // wide mode holds the low half until the high write
                    if (control_r[`FLD_WIDE_BIT]) begin
                        start_lo_hold_r <= wdata[11:0];
                    end else begin
                        start_lo_r <= wdata[11:0];
                    end
                end
                `CMD_START_HI: begin
                    start_hi_r <= wdata[11:0];
                    if (control_r[`FLD_WIDE_BIT]) begin
                        start_lo_r <= start_lo_hold_r;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // interval and burst words, each with its own two-bit prefix
    always_ff @(posedge clk) begin
        if (!nrst) begin
            interval_sel_r <= `RST_SEL;
            interval_mult_r <= `RST_MULT;
            interval_count_r <= `RST_INTERVAL;
            burst_sel_r <= `RST_SEL;
            burst_mult_r <= `RST_MULT;
            burst_count_r <= `RST_BURST;
        end else if (wr_en && addr == `ADDR_CMD) begin
            casez (wdata[15:12])
                `CMD_INTERVAL: begin
                    interval_sel_r <= wdata[`FLD_SEL_BIT];
                    interval_mult_r <=
                        wdata[`FLD_MULT_HI:`FLD_MULT_LO];
                    interval_count_r <= wdata[`FLD_CNT_HI:0];
                end
                `CMD_BURST: begin
                    burst_sel_r <= wdata[`FLD_SEL_BIT];
                    burst_mult_r <=
                        wdata[`FLD_MULT_HI:`FLD_MULT_LO];
                    burst_count_r <= wdata[`FLD_CNT_HI:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ========================================================
    // mode and time-base selection
    assign mode = step_mode(control_r[`FLD_MODE_HI:`FLD_MODE_LO]);
    assign cw = control_r[`FLD_CW_BIT];

    // external increment uses the burst word's own time base
    assign time_sel = (mode == sweep_timing_pkg::MODE_EXT_INC) ?
                      burst_sel_r : interval_sel_r;
    assign time_mult = (mode == sweep_timing_pkg::MODE_EXT_INC) ?
                       burst_mult_r : interval_mult_r;
    assign prescale_lim = mult_limit(time_mult);

    // base tick: one multiplied clock period or one output cycle
    assign tick = time_sel ? (prescale_r == prescale_lim) : wave_cycle;

    // ========================================================
    // sequencing events
    assign running = (state_r != sweep_timing_pkg::ST_IDLE);
    assign start_ev = !running && ctrl_rise;
    assign ext_step_ev = running && ctrl_rise &&
                         (mode != sweep_timing_pkg::MODE_AUTO);
    assign auto_int_end = running &&
                          (mode == sweep_timing_pkg::MODE_AUTO) && tick &&
                          (({1'b0, unit_cnt_r} + 12'h001) >=
                           {1'b0, interval_count_r});
    assign int_end = auto_int_end || ext_step_ev;
    assign step_ev = int_end && (step_cnt_r != incr_count_r);
    assign end_ev = int_end && (step_cnt_r == incr_count_r);
    assign restart = start_ev || step_ev;

    // burst ends after the programmed count of ticks
    assign burst_end = tick && !cw &&
                       (state_r == sweep_timing_pkg::ST_BURST) &&
                       (mode != sweep_timing_pkg::MODE_EXT_BOTH) &&
                       (({1'b0, unit_cnt_r} + 12'h001) >=
                        {1'b0, burst_count_r});

    // signed step, two's complement of the magnitude when negative
    assign step_mag = {1'b0, step_hi_r, step_lo_r};
    assign step_add = step_neg_r ? (24'h00_0000 - step_mag) : step_mag;

    // ========================================================
    // next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            sweep_timing_pkg::ST_IDLE: begin
                if (start_ev) begin
                    state_nxt = sweep_timing_pkg::ST_BURST;
                end
            end
            sweep_timing_pkg::ST_BURST,
            sweep_timing_pkg::ST_LISTEN: begin
                if (restart) begin
                    state_nxt = sweep_timing_pkg::ST_BURST;
                end else if (end_ev) begin
                    state_nxt = sweep_timing_pkg::ST_IDLE;
                end else if (mode == sweep_timing_pkg::MODE_EXT_BOTH) begin
                    // pin level sets burst and listen directly while cw is clear; cw holds burst
                    if (cw || ctrl_level) begin
                        state_nxt = sweep_timing_pkg::ST_BURST;
                    end else begin
                        state_nxt = sweep_timing_pkg::ST_LISTEN;
                    end
                end else if (cw) begin
                    state_nxt = sweep_timing_pkg::ST_BURST;
                end else if (burst_end) begin
                    state_nxt = sweep_timing_pkg::ST_LISTEN;
                end
            end
        endcase
    end

    // state register and the outputs that follow it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= sweep_timing_pkg::ST_IDLE;
            midscale_r <= 1'b1;
            sweep_active_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            midscale_r <= (state_nxt != sweep_timing_pkg::ST_BURST);
            sweep_active_r <= (state_nxt != sweep_timing_pkg::ST_IDLE);
        end
    end

    // ========================================================
    // time-base prescaler, restarted with each interval
    always_ff @(posedge clk) begin
        if (!nrst) begin
            prescale_r <= 9'h000;
        end else if (restart || !running || !time_sel) begin
            prescale_r <= 9'h000;
        end else if (prescale_r == prescale_lim) begin
            prescale_r <= 9'h000;
        end else begin
            prescale_r <= prescale_r + 9'h001;
        end
    end

    // ticks elapsed in the current interval, saturating
    always_ff @(posedge clk) begin
        if (!nrst) begin
            unit_cnt_r <= 11'h000;
        end else if (restart || !running) begin
            unit_cnt_r <= 11'h000;
        end else if (tick && unit_cnt_r != 11'h7ff) begin
            unit_cnt_r <= unit_cnt_r + 11'h001;
        end
    end

    // ========================================================
    // increments taken and the frequency being output
    always_ff @(posedge clk) begin
        if (!nrst) begin
            step_cnt_r <= 12'h000;
            freq_r <= 24'h00_0000;
        end else if (start_ev) begin
            step_cnt_r <= 12'h000;
            freq_r <= {start_hi_r, start_lo_r};
        end else if (step_ev) begin
            step_cnt_r <= step_cnt_r + 12'h001;
            freq_r <= freq_r + step_add;
        end
    end

    // one-cycle event flags
    always_ff @(posedge clk) begin
        if (!nrst) begin
            step_pulse_r <= 1'b0;
            sweep_done_r <= 1'b0;
        end else begin
            step_pulse_r <= step_ev;
            sweep_done_r <= end_ev;
        end
    end

    // ========================================================
    // read port, data valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_r <= 16'h0000;
        end else if (rd_en) begin
            unique case (addr)
                `ADDR_CMD: rdata_r <= {4'h0, control_r};
                `ADDR_STATUS: rdata_r <= {8'h00, ctrl_level, cw,
                                          control_r[`FLD_MODE_HI:
                                                    `FLD_MODE_LO],
                                          midscale_r, state_r};
                `ADDR_FREQ_LO: rdata_r <= {4'h0, freq_r[11:0]};
                `ADDR_FREQ_HI: rdata_r <= {4'h0, freq_r[23:12]};
                `ADDR_STEP: rdata_r <= {4'h0, step_cnt_r};
                `ADDR_INTERVAL: rdata_r <= {2'b00, interval_sel_r,
                                            interval_mult_r,
                                            interval_count_r};
                `ADDR_BURST: rdata_r <= {2'b00, burst_sel_r,
                                         burst_mult_r, burst_count_r};
                default: rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    // ========================================================
    // outputs straight from flip-flops
    assign rdata = rdata_r;
    assign freq_word = freq_r;
    assign midscale = midscale_r;
    assign sweep_active = sweep_active_r;
    assign step_pulse = step_pulse_r;
    assign sweep_done = sweep_done_r;

endmodule

// file: logic/sweep_timing_pkg.sv
// Purpose: types of the sweep interval and burst timing block
// Assumes: sweep_timing_regs.svh holds the numeric constants
// Notes: state codes are one-hot
`include "sweep_timing_regs.svh"

package sweep_timing_pkg;

    // ========================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BURST = 3'b010,
        ST_LISTEN = 3'b100
    } state_type;

    // ========================================================
    // stepping modes
    typedef enum logic [1:0] {
        MODE_AUTO = `MODE_CODE_AUTO,
        MODE_EXT_INC = `MODE_CODE_EXT_INC,
        MODE_EXT_BOTH = `MODE_CODE_EXT_BOTH
    } mode_type;

endpackage

// file: logic/sweep_timing_regs.svh
// Purpose: constants of the sweep interval and burst timing block
// Assumes: 16-bit configuration words, 200 MHz master clock
// Notes: offsets, field positions, reset values and timing counts
`ifndef SWEEP_TIMING_REGS_SVH
`define SWEEP_TIMING_REGS_SVH

// ========================================================
// register port addresses
`define ADDR_CMD 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_FREQ_LO 4'h2
`define ADDR_FREQ_HI 4'h3
`define ADDR_STEP 4'h4
`define ADDR_INTERVAL 4'h5
`define ADDR_BURST 4'h6

// ========================================================
// command word prefixes, bits 15 to 12
`define CMD_CONTROL 4'b0000
`define CMD_INCR_COUNT 4'b0001
`define CMD_STEP_LO 4'b0010
`define CMD_STEP_HI 4'b0011
`define CMD_INTERVAL 4'b01??
`define CMD_BURST 4'b10??
`define CMD_START_LO 4'b1100
`define CMD_START_HI 4'b1101

// ========================================================
// field positions
`define FLD_SEL_BIT 13
`define FLD_MULT_HI 12
`define FLD_MULT_LO 11
`define FLD_CNT_HI 10
`define FLD_WIDE_BIT 11
`define FLD_STEP_NEG_BIT 11
`define FLD_CW_BIT 7
`define FLD_MODE_HI 6
`define FLD_MODE_LO 5

// ========================================================
// stepping mode codes of the two mode bits
`define MODE_CODE_AUTO 2'b00
`define MODE_CODE_EXT_INC 2'b01
`define MODE_CODE_EXT_BOTH 2'b10

// ========================================================
// time-base prescale limits, multiplier minus one
`define MULT_LIMIT_1 9'h000
`define MULT_LIMIT_5 9'h004
`define MULT_LIMIT_100 9'h063
`define MULT_LIMIT_500 9'h1f3

// ========================================================
// reset values
`define RST_CONTROL 12'h000
`define RST_INCR_COUNT 12'h002
`define RST_INTERVAL 11'h002
`define RST_BURST 11'h001
`define RST_MULT 2'b00
`define RST_SEL 1'b1

`endif
